// [design/dwsl_host.sv]
// controller end: sends one seventeen-bit frame per request
`timescale 1ns/1ns
module dwsl_host
(
    input wire logic SYS_CLK,
    input wire logic RST_B,
    dwsl_if.host LINK,
    input wire logic START,
    input wire logic [7:0] WIPER_ZERO_TAP,
    input wire logic [7:0] WIPER_ONE_TAP,
    output logic BUSY,
    output logic [16:0] READ_BACK
);
    typedef enum logic [3:0]
    {
        ST_IDLE = 4'h1,
        ST_OPEN = 4'h2,
        ST_BITS = 4'h4,
        ST_CLOSE = 4'h8
    } dwsl_state_type;

    dwsl_state_type state_q;
    logic [2:0] half_q;
    logic [4:0] bit_q;
    logic [16:0] frame_q;
    logic [16:0] rd_q;
    logic [1:0] dout_sync_q;
    logic sclk_q;
    logic en_q;
    logic busy_q;
    logic tick;

    assign tick = (half_q == dwsl_pkg::HALF_LAST);

    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
            dout_sync_q <= 2'h0;
        else
            dout_sync_q <= {dout_sync_q[0], LINK.ser_dout};
    end

    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
            half_q <= dwsl_pkg::HALF_RESET;
        else if (state_q == ST_IDLE || tick)
            half_q <= dwsl_pkg::HALF_RESET;
        else
            half_q <= half_q + 3'h1;
    end

    // clock held low over every permit change: first rise a full period after permit rises, permit falls a half period after the last fall
    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            state_q <= ST_IDLE;
            sclk_q <= 1'b0;
            en_q <= 1'b0;
            busy_q <= 1'b0;
            bit_q <= dwsl_pkg::CNT_RESET;
            frame_q <= dwsl_pkg::FRAME_RESET;
            rd_q <= dwsl_pkg::FRAME_RESET;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                    if (START)
                    begin
                        frame_q <= {1'b0,
                            WIPER_ONE_TAP, WIPER_ZERO_TAP};
                        en_q <= 1'b1;
                        busy_q <= 1'b1;
                        bit_q <= dwsl_pkg::CNT_RESET;
                        state_q <= ST_OPEN;
                    end
                ST_OPEN:
                    if (tick)
                        state_q <= ST_BITS;
                ST_BITS:
                    if (tick)
                    begin
                        if (!sclk_q)
                        begin
                            sclk_q <= 1'b1; // data set up a half early
                            // the old bit lags a rise by both ends' syncs,
                            // so it is read a half period after the fall
                            if (bit_q != dwsl_pkg::CNT_RESET)
                                rd_q <= {rd_q[15:0], dout_sync_q[1]};
                        end
                        else
                        begin
                            sclk_q <= 1'b0;
                            frame_q <= {frame_q[15:0], 1'b0};
                            bit_q <= bit_q + 5'h01;
                            if (bit_q == dwsl_pkg::FRAME_LAST)
                                state_q <= ST_CLOSE;
                        end
                    end
                ST_CLOSE:
                    if (tick)
                    begin
                        rd_q <= {rd_q[15:0], dout_sync_q[1]};
                        en_q <= 1'b0;
                        busy_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                default:
                begin
                    state_q <= ST_IDLE;
                    busy_q <= 1'b0;
                end
            endcase
        end
    end

    assign LINK.ser_clk = sclk_q;
    assign LINK.ser_din = frame_q[16];
    assign LINK.wr_permit = en_q;
    assign BUSY = busy_q;
    assign READ_BACK = rd_q;
endmodule // dwsl_host

// [design/dwsl_pkg.sv]
// shared constants for the dual wiper serial loader
package dwsl_pkg;
    localparam int FRAME_BITS = 17;
    localparam int TAP_BITS = 8;
    localparam logic [4:0] FRAME_LAST = 5'h10;
    localparam logic [7:0] TAP_RESET = 8'h00;
    localparam logic [16:0] FRAME_RESET = 17'h00000;
    localparam logic [4:0] CNT_RESET = 5'h00;
    // wiper one sits in bits 15:8, wiper zero in 7:0 after a full frame
    localparam int TAP_ONE_LSB = 8;
    localparam int TAP_ZERO_LSB = 0;
    // nominal step size of the resistor ladder, milliohm-free integer ohms
    localparam int STEP_OHMS = 86;
    localparam int TAP_POSITIONS = 256;
    // host side serial clock: link period 800 ns at 100 ns system clock
    localparam int SYS_PERIOD_NS = 100;
    localparam int LINK_PERIOD_NS = 800;
    localparam int HALF_CYCLES = LINK_PERIOD_NS / (2 * SYS_PERIOD_NS);
    localparam logic [2:0] HALF_LAST = 3'(HALF_CYCLES - 1);
    localparam logic [2:0] HALF_RESET = 3'h0;
endpackage

// [design/dwsl_if.sv]
// pins between host and potentiometer serial loader
`timescale 1ns/1ns
interface dwsl_if;
    logic ser_clk;
    logic ser_din;
    logic wr_permit;
    logic ser_dout;
    modport dev (input ser_clk, input ser_din, input wr_permit,
        output ser_dout);
    modport host (output ser_clk, output ser_din, output wr_permit,
        input ser_dout);
endinterface

// [design/dwsl_device.sv]
// potentiometer end: serial shift register and wiper tap latches
//
// Contract
// - accept exactly seventeen-bit frames, one bit per rising edge
// - host sends low lead bit first
// - next eight bits set wiper one tap
// - last eight bits set wiper zero tap
// - tap codes eight bits, msb first, 256 steps
// - each tap step is one 86 ohm increment
// - shift only while permit high, freeze otherwise
// - sample data on serial clock rising edge
// - old frame bits shift out while permitted
`timescale 1ns/1ns
module dwsl_device
(
    input wire logic SYS_CLK,
    input wire logic RST_B,
    dwsl_if.dev LINK,
    output logic [7:0] WIPER_ZERO_TAP,
    output logic [7:0] WIPER_ONE_TAP,
    output logic FRAME_OK
);
    logic [2:0] clk_sync_q;
    logic [1:0] din_sync_q;
    logic [1:0] en_sync_q;
    logic clk_rise;
    logic en_fall;
    logic en_prev_q;
    logic [16:0] shift_q;
    logic [4:0] count_q;
    logic dout_q;
    logic [7:0] w0_q;
    logic [7:0] w1_q;
    logic ok_q;

    // a frame counts only at exactly seventeen bits with a low lead bit
    function automatic logic frame_good(input logic [4:0] cnt,
        input logic lead);
        return (cnt == dwsl_pkg::FRAME_LAST + 5'h01) && !lead;
    endfunction

    // two stages before use; third stage only for edge finding
    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            clk_sync_q <= 3'h0;
            din_sync_q <= 2'h0;
            en_sync_q <= 2'h0;
            en_prev_q <= 1'b0;
        end
        else
        begin
            clk_sync_q <= {clk_sync_q[1:0], LINK.ser_clk};
            din_sync_q <= {din_sync_q[0], LINK.ser_din};
            en_sync_q <= {en_sync_q[0], LINK.wr_permit};
            en_prev_q <= en_sync_q[1];
        end
    end

    assign clk_rise = clk_sync_q[1] && !clk_sync_q[2];
    assign en_fall = en_prev_q && !en_sync_q[1];

    // msb-first shift; the bit leaving the top goes out on the pin
    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            shift_q <= dwsl_pkg::FRAME_RESET;
            dout_q <= 1'b0;
        end
        else if (clk_rise && en_sync_q[1])
        begin
            shift_q <= {shift_q[15:0], din_sync_q[1]};
            dout_q <= shift_q[16];
        end
    end

    // counts bits of the open frame; stops at eighteen so that a long
    // frame never looks like a complete one
    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
            count_q <= dwsl_pkg::CNT_RESET;
        else if (!en_sync_q[1])
            count_q <= dwsl_pkg::CNT_RESET;
        else if (clk_rise && count_q <= dwsl_pkg::FRAME_LAST + 5'h01)
            count_q <= count_q + 5'h01;
    end

    // taps move only on permit fall, and only for a complete frame;
    // short or long frames are dropped so a glitch cannot jolt volume
    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            w0_q <= dwsl_pkg::TAP_RESET;
            w1_q <= dwsl_pkg::TAP_RESET;
            ok_q <= 1'b0;
        end
        else if (en_fall)
        begin
            ok_q <= frame_good(count_q, shift_q[16]);
            if (frame_good(count_q, shift_q[16]))
            begin
                w1_q <= shift_q[dwsl_pkg::TAP_ONE_LSB +:
                    dwsl_pkg::TAP_BITS];
                w0_q <= shift_q[dwsl_pkg::TAP_ZERO_LSB +:
                    dwsl_pkg::TAP_BITS];
            end
        end
    end

    assign LINK.ser_dout = dout_q;
    assign WIPER_ZERO_TAP = w0_q;
    assign WIPER_ONE_TAP = w1_q;
    assign FRAME_OK = ok_q;
endmodule // dwsl_device

// [verif/dwsl_monitor.sv]
// wire checks on the link joining host and device
`timescale 1ns/1ns
module dwsl_monitor
(
    input wire logic SYS_CLK,
    input wire logic RST_B,
    input wire logic ser_clk,
    input wire logic ser_din,
    input wire logic wr_permit,
    input wire logic ser_dout
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_B);
    logic [4:0] rises_q;
    logic clk_q;
    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
            clk_q <= 1'b0;
        else
            clk_q <= ser_clk;
    end
    // rises seen inside the current permit window
    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
            rises_q <= 5'h00;
        else if (!wr_permit)
            rises_q <= 5'h00;
        else if (ser_clk && !clk_q)
            rises_q <= rises_q + 5'h01;
    end
    chk_frame_len: assert property
        ($fell(wr_permit) |-> rises_q == 5'h11)
        else $error("window closed without 17 rises");
    chk_lead_low: assert property
        ($rose(ser_clk) && rises_q == 5'h00 |-> !ser_din)
        else $error("lead bit not low");
    chk_clk_idle: assert property
        (!wr_permit |-> !ser_clk)
        else $error("serial clock high outside window");
    chk_permit_quiet: assert property
        ($changed(wr_permit) |-> !ser_clk [*3])
        else $error("serial clock moved near permit change");
    chk_din_hold: assert property
        (ser_clk |-> $stable(ser_din))
        else $error("data moved while clock high");
    chk_high_width: assert property
        ($rose(ser_clk) |-> ser_clk [*4] ##1 !ser_clk)
        else $error("clock high phase not 4 cycles");
    chk_dout_frozen: assert property
        (!wr_permit && !$past(wr_permit) |-> $stable(ser_dout))
        else $error("dout moved while frozen");
    chk_dout_lag: assert property
        ($changed(ser_dout) |-> $past(ser_clk, 3) || $past(ser_clk, 4))
        else $error("dout changed without a clock rise");
endmodule // dwsl_monitor

// [verif/tb.sv]
// self-checking bench: joined ends plus a bench-driven device
`timescale 1ns/1ns
module tb;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic start = 1'b0;
    logic [7:0] h0 = 8'h00;
    logic [7:0] h1 = 8'h00;
    logic busy, ok, b_ok;
    logic [16:0] rd, prev;
    logic [7:0] t0, t1, b0, b1;
    logic [16:0] b_model = 17'h00000;
    logic [31:0] seed = 32'h4EAA;
    int failures = 0;
    int checks_done = 0;
    dwsl_if link ();
    dwsl_if link_b ();
    dwsl_host u_dwsl_host (.SYS_CLK(sys_clk), .RST_B(rst_b), .LINK(link),
        .START(start), .WIPER_ZERO_TAP(h0), .WIPER_ONE_TAP(h1),
        .BUSY(busy), .READ_BACK(rd));
    dwsl_device u_dwsl_device (.SYS_CLK(sys_clk), .RST_B(rst_b),
        .LINK(link), .WIPER_ZERO_TAP(t0), .WIPER_ONE_TAP(t1), .FRAME_OK(ok));
    dwsl_device u_dwsl_device_b (.SYS_CLK(sys_clk), .RST_B(rst_b),
        .LINK(link_b), .WIPER_ZERO_TAP(b0), .WIPER_ONE_TAP(b1),
        .FRAME_OK(b_ok));
    dwsl_monitor u_dwsl_monitor (.SYS_CLK(sys_clk), .RST_B(rst_b),
        .ser_clk(link.ser_clk), .ser_din(link.ser_din),
        .wr_permit(link.wr_permit), .ser_dout(link.ser_dout));
    always #50 sys_clk = ~sys_clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [16:0] frame_of(input logic [15:0] v);
        return {1'b0, v};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #10;
    endtask
    task automatic check(input string what, input logic [16:0] seen, exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic host_send(input logic [15:0] v);
        h1 = v[15:8];
        h0 = v[7:0];
        start = 1'b1;
        tick(1);
        start = 1'b0;
        tick(1);
        for (int i = 0; i < 400 && busy !== 1'b0; i++)
            tick(1);
        check("busy", busy, 1'b0);
        tick(8);
        check("wiper one", t1, v[15:8]);
        check("wiper zero", t0, v[7:0]);
        check("frame ok", ok, 1'b1);
        check("read back", rd, prev);
        prev = frame_of(v);
    endtask
    // bench as host; n other than 17 or a high lead bit break the frame;
    // b_model mirrors the device shift register to predict its dout
    task automatic dev_send(input logic [17:0] f, input int n);
        logic [16:0] got;
        logic [16:0] exp_got;
        got = 17'h00000;
        exp_got = 17'h00000;
        link_b.wr_permit = 1'b1;
        for (int i = n - 1; i >= 0; i--)
        begin
            link_b.ser_din = f[i];
            tick(4);
            link_b.ser_clk = 1'b1;
            tick(4);
            got = {got[15:0], link_b.ser_dout};
            exp_got = {exp_got[15:0], b_model[16]};
            b_model = {b_model[15:0], f[i]};
            link_b.ser_clk = 1'b0;
        end
        check("b dout", got, exp_got);
        tick(4);
        link_b.wr_permit = 1'b0;
        link_b.ser_din = ~f[0];
        tick(8);
    endtask
    initial
    begin
        #2000000;
        failures++;
        report_and_stop();
    end
    initial
    begin
        link_b.ser_clk = 1'b0;
        link_b.ser_din = 1'b0;
        link_b.wr_permit = 1'b0;
        tick(8);
        rst_b = 1'b1;
        prev = 17'h00000;
        host_send(16'h00FF);
        host_send(16'hFF00);
        host_send(16'h8001);
        for (int k = 0; k < 12; k++)
        begin
            seed = xs(seed);
            host_send(seed[15:0]);
        end
        dev_send(18'h052AE, 17);
        check("b ok", b_ok, 1'b1);
        dev_send(18'h1C33C, 17);
        check("b lead", b_ok, 1'b0);
        dev_send(18'h0C33C, 16);
        check("b short", b_ok, 1'b0);
        // one bit too many: the last seventeen alone would be a good frame
        dev_send(18'h21234, 18);
        check("b long", b_ok, 1'b0);
        // stray clocks with permit low must not shift
        for (int k = 0; k < 17; k++)
        begin
            link_b.ser_din = k[0];
            tick(4);
            link_b.ser_clk = 1'b1;
            tick(4);
            link_b.ser_clk = 1'b0;
        end
        tick(8);
        check("b taps", {b1, b0}, 16'h52AE);
        // a stray shift above would show up in this frame's dout stream
        seed = xs(seed);
        dev_send({2'b00, seed[15:0]}, 17);
        check("b new taps", {b1, b0}, seed[15:0]);
        report_and_stop();
    end
endmodule // tb
